//--- hw/ext_exec.sv
// executor for the escape-prefixed instruction extensions
// assumes fetch hands over opcode bytes with a valid strobe and an apb master
//
// Function
// - An extended instruction starts with escape byte a5 and a second byte picks the operation.
// - The alternate increment adds one to the unselected 16-bit pointer with wrap and no flags.
// - The alternate increment is a5 then a3 and takes three cycles.
// - The relative jump adds pc plus two and the unsigned accumulator to form the next fetch.
// - The shift left moves the 40-bit accumulator left, zero into bit 0, no flags.
// - The code load reads program memory at accumulator plus alternate pointer into a.
// - The multiply-accumulate adds the signed 16x16 product into the 40-bit accumulator.
// - Overflow is set on signed overflow else kept, carry follows the sign of the result.
// - The immediate load writes byte three high and byte four low into the alternate pointer.
// - The external read loads a from the space addressed by the alternate pointer.
// - The external read takes three cycles on extended ram and five on flash or external data.
// - The external write stores a at the space addressed by the alternate pointer.
// - With debug off the breakpoint is a two-cycle no-operation.
`timescale 1ns/1ps
module ext_exec #(
    parameter int DEPTH_LOG2 = 8,
    parameter logic [15:0] RAM_TOP = 16'h047f,
    parameter logic [15:0] FLASH_BASE = 16'hf000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        op_valid,
    input  wire logic [7:0]  op_byte,
    output logic             op_ready,
    output logic             jump_valid,
    output logic [15:0]      jump_addr,
    output logic             debug_halt,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import ext_exec_pkg::*;
    initial begin
        if (DEPTH_LOG2 < 1 || DEPTH_LOG2 > 16) $error("bad depth");
    end

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_second = 3'b001,
        st_imm_hi = 3'b010,
        st_imm_lo = 3'b011,
        st_run    = 3'b100
    } state_e;

    state_e      state_q;
    logic [7:0]  opcode_q;
    logic [3:0]  count_q;
    logic [15:0] dp_zero_q;
    logic [15:0] dp_one_q;
    logic [7:0]  acc_q;
    logic [7:0]  b_q;
    logic [7:0]  ax_q;
    logic [7:0]  bx_q;
    logic [39:0] mac_q;
    logic        select_q;
    logic        debug_en_q;
    logic        carry_q;
    logic        ovf_q;
    logic        break_seen_q;
    logic [15:0] pc_q;
    logic [7:0]  imm_hi_q;
    mem_req_s    req_d;
    logic [7:0]  mem_rdata;
    logic        apb_wr;
    logic        apb_rd;

    // alternate pointer picks the one not selected
    function automatic logic [15:0] alt_ptr(input logic sel, input logic [15:0] p0,
                                           input logic [15:0] p1);
        alt_ptr = sel ? p0 : p1;
    endfunction : alt_ptr

    // space decode by address window
    function automatic space_e space_of(input logic [15:0] a);
        if (a <= RAM_TOP) begin
            space_of = space_ext_ram;
        end else if (a >= FLASH_BASE) begin
            space_of = space_flash;
        end else begin
            space_of = space_ext_data;
        end
    endfunction : space_of

    logic [15:0] alt_q;
    assign alt_q = alt_ptr(select_q, dp_zero_q, dp_one_q);

    // signed multiply-accumulate terms
    logic signed [15:0] opa;
    logic signed [15:0] opb;
    logic signed [31:0] product;
    logic signed [39:0] mac_sum;
    assign opa     = {ax_q, acc_q};
    assign opb     = {bx_q, b_q};
    assign product = opa * opb;
    assign mac_sum = $signed(mac_q) + 40'(product);

    // cycles that each second byte takes
    function automatic logic [3:0] cycles_of(input logic [7:0] op, input space_e sp);
        unique case (op)
            op_alt_increment: cycles_of = cyc_increment;
            op_break:         cycles_of = cyc_break;
            op_shift_left:    cycles_of = cyc_shift;
            op_mac:           cycles_of = cyc_mac;
            op_pc_jump:       cycles_of = cyc_jump;
            op_code_load:     cycles_of = cyc_code_load;
            op_alt_load:      cycles_of = cyc_alt_load;
            op_ext_read, op_ext_write:
                cycles_of = (sp == space_ext_ram) ? cyc_ext_fast : cyc_ext_slow;
            default:          cycles_of = cyc_break;
        endcase
    endfunction : cycles_of

    // decode sequencer: escape, second byte, then either the two immediates or the run count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= st_idle;
            opcode_q <= 8'h00;
            count_q  <= 4'h0;
            imm_hi_q <= 8'h00;
        end else begin
            unique case (state_q)
                st_idle: begin
                    if (op_valid && op_byte == escape_opcode) begin
                        state_q <= st_second;
                    end
                end
                st_second: begin
                    if (op_valid) begin
                        opcode_q <= op_byte;
                        if (op_byte == op_alt_load) begin
                            state_q <= st_imm_hi;
                        end else begin
                            state_q <= st_run;
                        end
                        // first two cycles spent on the two opcode bytes
                        count_q <= cycles_of(op_byte, space_of(alt_q)) - 4'h2;
                    end
                end
                st_imm_hi: begin
                    if (op_valid) begin
                        imm_hi_q <= op_byte;
                        state_q  <= st_imm_lo;
                    end
                end
                st_imm_lo: begin
                    if (op_valid) begin
                        state_q <= st_idle;
                    end
                end
                st_run: begin
                    if (count_q <= 4'h1) begin
                        state_q <= st_idle;
                    end else begin
                        count_q <= count_q - 4'h1;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // last run cycle commits the instruction
    logic commit;
    assign commit = (state_q == st_run) && (count_q <= 4'h1);
    logic second_done;
    assign second_done = (state_q == st_second) && op_valid;

    // fetch is stalled while an instruction runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ready <= 1'b1;
        end else begin
            // two-cycle instructions never stall fetch
            op_ready <= !(second_done && op_byte != op_alt_load &&
                          cycles_of(op_byte, space_of(alt_q)) > 4'h2) &&
                        !(state_q == st_run && !commit);
        end
    end

    // data pointers: increment, immediate load, software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_zero_q <= 16'h0000;
            dp_one_q  <= 16'h0000;
        end else if (commit && opcode_q == op_alt_increment) begin
            if (select_q) dp_zero_q <= dp_zero_q + 16'h0001;
            else          dp_one_q  <= dp_one_q + 16'h0001;
        end else if (state_q == st_imm_lo && op_valid) begin
            if (select_q) dp_zero_q <= {imm_hi_q, op_byte};
            else          dp_one_q  <= {imm_hi_q, op_byte};
        end else if (apb_wr && paddr == reg_pointer_zero) begin
            dp_zero_q <= pwdata[15:0];
        end else if (apb_wr && paddr == reg_pointer_one) begin
            dp_one_q <= pwdata[15:0];
        end
    end

    // request driven at decode, so read data is registered before a fast commit
    always_comb begin
        req_d = '0;
        if (second_done && op_byte == op_code_load) begin
            req_d.valid = 1'b1;
            req_d.space = space_code;
            req_d.addr  = alt_q + {8'h00, acc_q};
        end else if (second_done && (op_byte == op_ext_read || op_byte == op_ext_write)) begin
            req_d.valid = 1'b1;
            req_d.write = (op_byte == op_ext_write);
            req_d.space = space_of(alt_q);
            req_d.addr  = alt_q;
            req_d.wdata = acc_q;
        end
    end

    ext_mem_port #(.DEPTH_LOG2(DEPTH_LOG2)) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req_d),
        .rdata   (mem_rdata)
    );

    // accumulator and operand registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 8'h00;
            b_q   <= 8'h00;
            ax_q  <= 8'h00;
            bx_q  <= 8'h00;
        end else if (commit && (opcode_q == op_code_load || opcode_q == op_ext_read)) begin
            acc_q <= mem_rdata;
        end else if (apb_wr && paddr == reg_operands) begin
            {bx_q, b_q, ax_q, acc_q} <= pwdata;
        end
    end

    // 40-bit accumulator: shift, multiply-accumulate, software load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_q <= 40'h0;
        end else if (commit && opcode_q == op_shift_left) begin
            mac_q <= {mac_q[38:0], 1'b0};
        end else if (commit && opcode_q == op_mac) begin
            mac_q <= mac_sum;
        end else if (apb_wr && paddr == reg_accum_low) begin
            mac_q[31:0] <= pwdata;
        end else if (apb_wr && paddr == reg_accum_high) begin
            mac_q[39:32] <= pwdata[7:0];
        end
    end

    // flags only move on multiply-accumulate; overflow is sticky until software clears
    logic ovf_now;
    assign ovf_now = (mac_q[39] == product[31]) && (mac_sum[39] != mac_q[39]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_q <= 1'b0;
            ovf_q   <= 1'b0;
        end else if (commit && opcode_q == op_mac) begin
            carry_q <= mac_sum[39];
            if (ovf_now) ovf_q <= 1'b1;
        end else if (apb_wr && paddr == reg_status) begin
            if (pwdata[st_ovf_bit]) ovf_q <= 1'b0;
            if (pwdata[st_carry_bit]) carry_q <= 1'b0;
        end
    end

    // program counter, jump target and debug halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q         <= 16'h0000;
            jump_valid   <= 1'b0;
            jump_addr    <= 16'h0000;
            debug_halt   <= 1'b0;
            break_seen_q <= 1'b0;
        end else begin
            jump_valid <= 1'b0;
            debug_halt <= 1'b0;
            if (commit && opcode_q == op_pc_jump) begin
                jump_valid <= 1'b1;
                jump_addr  <= pc_q + 16'h0002 + {8'h00, acc_q};
            end
            // with debug off the breakpoint does nothing beyond its two cycles
            if (commit && opcode_q == op_break && debug_en_q) begin
                debug_halt   <= 1'b1;
                break_seen_q <= 1'b1;
            end else if (apb_wr && paddr == reg_status && pwdata[st_break_bit]) begin
                break_seen_q <= 1'b0;
            end
            if (apb_wr && paddr == reg_program_ctr) begin
                pc_q <= pwdata[15:0];
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_q   <= 1'b0;
            debug_en_q <= 1'b0;
        end else if (apb_wr && paddr == reg_control) begin
            select_q   <= pwdata[ctl_select_bit];
            debug_en_q <= pwdata[ctl_debug_bit];
        end
    end

    // apb slave: zero wait states, unmapped reads zero with error
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > reg_program_ctr || paddr[1:0] != 2'b00);
            if (apb_rd) begin
                unique case (paddr)
                    reg_pointer_zero: prdata <= {16'h0, dp_zero_q};
                    reg_pointer_one:  prdata <= {16'h0, dp_one_q};
                    reg_operands:     prdata <= {bx_q, b_q, ax_q, acc_q};
                    reg_accum_low:    prdata <= mac_q[31:0];
                    reg_accum_high:   prdata <= {24'h0, mac_q[39:32]};
                    reg_control:      prdata <= {30'h0, debug_en_q, select_q};
                    reg_status:       prdata <= {28'h0, break_seen_q, ovf_q, carry_q,
                                                 state_q != st_idle};
                    reg_program_ctr:  prdata <= {16'h0, pc_q};
                    default:          prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule : ext_exec

//--- include/ext_exec_pkg.sv
// constants and carriers for the escape-prefixed instruction executor
// assumes one clock domain and an APB master for the register view
package ext_exec_pkg;
    // opcodes
    localparam logic [7:0] escape_opcode     = 8'ha5;
    localparam logic [7:0] op_break          = 8'h00;
    localparam logic [7:0] op_shift_left     = 8'h23;
    localparam logic [7:0] op_alt_increment  = 8'ha3;
    localparam logic [7:0] op_mac            = 8'ha4;
    localparam logic [7:0] op_pc_jump        = 8'h73;
    localparam logic [7:0] op_code_load      = 8'h93;
    localparam logic [7:0] op_alt_load       = 8'h90;
    localparam logic [7:0] op_ext_read       = 8'he0;
    localparam logic [7:0] op_ext_write      = 8'hf0;
    // cycle counts for each instruction
    localparam logic [3:0] cyc_increment     = 4'h3;
    localparam logic [3:0] cyc_break         = 4'h2;
    localparam logic [3:0] cyc_shift         = 4'h2;
    localparam logic [3:0] cyc_mac           = 4'h9;
    localparam logic [3:0] cyc_jump          = 4'h3;
    localparam logic [3:0] cyc_code_load     = 4'h3;
    localparam logic [3:0] cyc_alt_load      = 4'h4;
    localparam logic [3:0] cyc_ext_fast      = 4'h3;
    localparam logic [3:0] cyc_ext_slow      = 4'h5;
    // apb register offsets
    localparam logic [7:0] reg_pointer_zero  = 8'h00;
    localparam logic [7:0] reg_pointer_one   = 8'h04;
    localparam logic [7:0] reg_operands      = 8'h08;
    localparam logic [7:0] reg_accum_low     = 8'h0c;
    localparam logic [7:0] reg_accum_high    = 8'h10;
    localparam logic [7:0] reg_control       = 8'h14;
    localparam logic [7:0] reg_status        = 8'h18;
    localparam logic [7:0] reg_program_ctr   = 8'h1c;
    // control fields
    localparam int ctl_select_bit  = 0;
    localparam int ctl_debug_bit   = 1;
    // status fields
    localparam int st_busy_bit     = 0;
    localparam int st_carry_bit    = 1;
    localparam int st_ovf_bit      = 2;
    localparam int st_break_bit    = 3;
    // memory space selectors
    typedef enum logic [1:0] {
        space_ext_ram   = 2'b00,
        space_flash     = 2'b01,
        space_ext_data  = 2'b10,
        space_code      = 2'b11
    } space_e;
    // memory request carried to the single memory port
    typedef struct packed {
        logic        valid;
        logic        write;
        space_e      space;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;
endpackage : ext_exec_pkg

//--- hw/ext_mem_port.sv
// one-cycle registered memory responder standing for the data and code spaces
// assumes requests come from the executor on the same clock
`timescale 1ns/1ps
module ext_mem_port #(
    parameter int DEPTH_LOG2 = 8
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire ext_exec_pkg::mem_req_s req,
    output logic [7:0]                 rdata
);
    import ext_exec_pkg::*;
    initial begin
        if (DEPTH_LOG2 < 1 || DEPTH_LOG2 > 16) $error("bad depth");
    end
    // one array for all spaces, index includes the space code
    logic [7:0] mem [0:(4 << DEPTH_LOG2) - 1];
    logic [DEPTH_LOG2+1:0] idx;
    assign idx = {req.space, req.addr[DEPTH_LOG2-1:0]};
    // storage writes, no reset so it maps to ram
    always_ff @(posedge pclk) begin
        if (req.valid && req.write) begin
            mem[idx] <= req.wdata;
        end
    end
    // read data comes out of a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
        end else if (req.valid && !req.write) begin
            rdata <= mem[idx];
        end
    end
endmodule : ext_mem_port

//--- tb/fetch_source.sv
// instruction byte source standing for program memory on the fetch side
// assumes the bench pulses go for one cycle with up to four bytes, first byte highest
`timescale 1ns/1ps
module fetch_source (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic [31:0] word,
    input  wire logic [2:0]  count,
    output logic             op_valid,
    output logic [7:0]       op_byte,
    output logic             busy
);
    logic [31:0] sh_q;
    logic [2:0]  left_q;

    // bytes leave most significant first, so the escape leads and immediates go hi then lo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q     <= 32'h0;
            left_q   <= 3'h0;
            op_valid <= 1'b0;
            op_byte  <= 8'h5a;
        end else if (go && left_q == 3'h0) begin
            sh_q     <= word << 8;
            left_q   <= count - 3'h1;
            op_valid <= 1'b1;
            op_byte  <= word[31:24];
        end else if (left_q != 3'h0) begin
            sh_q     <= sh_q << 8;
            left_q   <= left_q - 3'h1;
            op_byte  <= sh_q[31:24];
        end else begin
            op_valid <= 1'b0;
            op_byte  <= ~op_byte; // idle bus toggles so stale bytes never look valid
        end
    end

    assign busy = op_valid;
endmodule : fetch_source

//--- tb/ext_exec_checker.sv
// port assertions for the escape-prefixed executor
// assumes a single clock and no escape value inside immediate bytes
`timescale 1ns/1ps
module ext_exec_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        op_valid,
    input wire logic [7:0]  op_byte,
    input wire logic        op_ready,
    input wire logic        jump_valid,
    input wire logic [15:0] jump_addr,
    input wire logic        debug_halt,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    import ext_exec_pkg::*;
    logic esc_q;
    logic take;

    // escape byte seen, so the next valid byte is the opcode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esc_q <= 1'b0;
        end else if (op_valid) begin
            esc_q <= (op_byte == escape_opcode) && !esc_q;
        end
    end
    assign take = esc_q && op_valid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than a cycle");
    a_unmapped_read_err: assert property (psel && !penable && !pwrite && paddr > 8'h1c
        |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    a_inc_three_cycles: assert property (take && op_byte == op_alt_increment
        |=> !op_ready ##1 op_ready) else $error("increment length wrong");
    a_break_two_cycles: assert property (take && op_byte == op_break
        |=> op_ready [*2]) else $error("breakpoint stalled");
    a_read_length_span: assert property (take && op_byte == op_ext_read
        |=> !op_ready ##[1:3] op_ready) else $error("external read length wrong");
    a_jump_after_op: assert property (take && op_byte == op_pc_jump
        |-> ##2 jump_valid) else $error("jump not issued");
    a_jump_one_pulse: assert property (jump_valid |=> !jump_valid)
        else $error("jump pulse too long");
    a_halt_one_pulse: assert property (debug_halt |=> !debug_halt)
        else $error("halt pulse too long");
    a_ready_comes_back: assert property (!op_ready |-> ##[1:8] op_ready)
        else $error("executor stuck busy");
endmodule : ext_exec_checker

bind ext_exec ext_exec_checker i_ext_exec_checker (.*);

//--- tb/ext_exec_tb.sv
// self-checking bench for the escape-prefixed executor
// assumes the fetch source model on the byte side and apb for setup and readback
`timescale 1ns/1ps
module ext_exec_tb;
    import ext_exec_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        go = 1'b0;
    logic [31:0] word = 32'h0;
    logic [2:0]  count = 3'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        op_valid, src_busy;
    logic [7:0]  op_byte;
    logic        op_ready, jump_valid, debug_halt, pready, pslverr;
    logic [15:0] jump_addr, seen_jump;
    logic [31:0] prdata, rd;
    logic        er;
    logic [39:0] m;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          halts = 0;
    int          lo, h;
    logic [15:0] ext_addr [3] = '{16'h0040, 16'h2000, 16'hf010};
    logic [7:0]  ext_data [3] = '{8'h3c, 8'h77, 8'h9a};
    int          ext_lo [3] = '{1, 3, 3};
    logic [39:0] mac_init [4] = '{40'h0, 40'h0, 40'h7fffffffff, 40'h0};
    logic [31:0] mac_ops [4] = '{32'h00a00050, 32'h00a0ffb0, 32'h00a00050, 32'h00a00050};
    logic [39:0] mac_exp [4] = '{40'h3200, 40'hffffffce00, 40'h80000031ff, 40'h3200};
    logic [1:0]  mac_fl [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

    ext_exec i_ext_exec (.*);
    fetch_source i_fetch_source (.pclk(pclk), .presetn(presetn), .go(go), .word(word),
        .count(count), .op_valid(op_valid), .op_byte(op_byte), .busy(src_busy));

    always #10 pclk = ~pclk;

    // capture pulses and cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (jump_valid === 1'b1) seen_jump <= jump_addr;
        if (debug_halt === 1'b1) halts++;
        if (cycles == 8000) begin
            err_count++;
            test_done();
        end
    end

    task check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // send an instruction, then count cycles with op_ready low into lo
    task run(input logic [31:0] w, input logic [2:0] n);
        @(posedge pclk);
        go <= 1'b1;
        word <= w;
        count <= n;
        @(posedge pclk);
        go <= 1'b0;
        #1;
        while (src_busy === 1'b1) begin
            @(posedge pclk);
            #1;
        end
        lo = 0;
        while (op_ready !== 1'b1) begin
            @(posedge pclk);
            #1;
            lo++;
        end
        repeat (2) @(posedge pclk);
    endtask : run

    task test_done();
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("ready", op_ready, 40'h1);
        apb(1'b0, 8'h20, 32'h0);
        check("err", {er, rd}, {1'b1, 32'h0});
        // alternate pointer increment with carry and both selections
        apb(1'b1, reg_control, 32'h0);
        apb(1'b1, reg_pointer_zero, 32'h0);
        apb(1'b1, reg_pointer_one, 32'h12fe);
        run(32'ha3000000, 3'd1); // lone byte without escape must not act
        repeat (3) begin
            run(32'ha5a30000, 3'd2);
            check("inc len", lo, 40'h1);
        end
        apb(1'b0, reg_pointer_one, 32'h0);
        check("ptr1", rd[15:0], 40'h1301);
        apb(1'b1, reg_control, 32'h1);
        apb(1'b1, reg_pointer_zero, 32'hffff);
        run(32'ha5a30000, 3'd2);
        apb(1'b0, reg_pointer_zero, 32'h0);
        check("ptr0 wrap", rd[15:0], 40'h0);
        apb(1'b0, reg_pointer_one, 32'h0);
        check("ptr1 kept", rd[15:0], 40'h1301);
        // immediate load sets the alternate pointer and code load leaves it alone
        apb(1'b1, reg_control, 32'h0);
        run(32'ha5905678, 3'd4);
        apb(1'b0, reg_pointer_one, 32'h0);
        check("imm", rd[15:0], 40'h5678);
        run(32'ha5930000, 3'd2);
        check("code len", lo, 40'h1);
        apb(1'b0, reg_pointer_one, 32'h0);
        check("code ptr", rd[15:0], 40'h5678);
        // write then read ext ram, ext data and flash through the alternate pointer
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, reg_pointer_one, {16'h0, ext_addr[i]});
            apb(1'b1, reg_operands, {24'h0, ext_data[i]});
            run(32'ha5f00000, 3'd2);
            check("wr len", lo, ext_lo[i]);
            apb(1'b1, reg_operands, 32'h0);
            run(32'ha5e00000, 3'd2);
            check("rd len", lo, ext_lo[i]);
            apb(1'b0, reg_operands, 32'h0);
            check("rd data", rd[7:0], ext_data[i]);
        end
        // multiply-accumulate results and flags
        apb(1'b1, reg_status, 32'he);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, reg_accum_low, mac_init[i][31:0]);
            apb(1'b1, reg_accum_high, {24'h0, mac_init[i][39:32]});
            apb(1'b1, reg_operands, mac_ops[i]);
            run(32'ha5a40000, 3'd2);
            apb(1'b0, reg_accum_low, 32'h0);
            m[31:0] = rd;
            apb(1'b0, reg_accum_high, 32'h0);
            m[39:32] = rd[7:0];
            check("mac", m, mac_exp[i]);
            apb(1'b0, reg_operands, 32'h0);
            check("mac ops", rd, mac_ops[i]);
            apb(1'b0, reg_status, 32'h0);
            check("mac flags", rd[2:1], mac_fl[i]);
        end
        // shift left keeps flags
        apb(1'b1, reg_accum_low, 32'hb1a29384);
        apb(1'b1, reg_accum_high, 32'hc5);
        run(32'ha5230000, 3'd2);
        apb(1'b0, reg_accum_low, 32'h0);
        m[31:0] = rd;
        apb(1'b0, reg_accum_high, 32'h0);
        m[39:32] = rd[7:0];
        check("shift", m, 40'h8b63452708);
        apb(1'b0, reg_status, 32'h0);
        check("shift flags", rd[2:1], 40'h2);
        // relative jump with wrap and with carry into the high byte
        apb(1'b1, reg_operands, 32'h05);
        apb(1'b1, reg_program_ctr, 32'hfffe);
        run(32'ha5730000, 3'd2);
        check("jump wrap", seen_jump, 40'h0005);
        apb(1'b1, reg_operands, 32'h20);
        apb(1'b1, reg_program_ctr, 32'h10f0);
        run(32'ha5730000, 3'd2);
        check("jump carry", seen_jump, 40'h1112);
        apb(1'b0, reg_operands, 32'h0);
        check("jump acc", rd, 40'h20);
        // breakpoint with debug off, then on
        apb(1'b1, reg_status, 32'he);
        h = halts;
        run(32'ha5000000, 3'd2);
        check("break len", lo, 40'h0);
        apb(1'b0, reg_status, 32'h0);
        check("break off", {halts - h, rd[3]}, 40'h0);
        apb(1'b1, reg_control, 32'h2);
        run(32'ha5000000, 3'd2);
        apb(1'b0, reg_status, 32'h0);
        check("break on", {halts - h, rd[3]}, 40'h3);
        test_done();
    end
endmodule : ext_exec_tb
